// >>> core/cce_pkg.sv
// Behaviour
// - Keep year, month, date, weekday, hour, minute and second at one-second resolution.
// - Year register holds the full four-digit year value.
// - Weekday runs 1 for Monday up to 7 for Sunday.
// - No battery, or battery gone over 15 seconds, marks clock data lost.
// - While in error, light the indicator and show a status bit.
// - Corrupted contents or damaged clock hardware also raise the error.
// - All seven date and time registers read and write as plain integers.
// - Time query returns hours*10000 + minutes*100 + seconds as one integer.
// - With module fitted, add or drop calibration seconds per 72 hours.
// - Module counts a 32.768 kHz crystal; calibration applies only there.
// - Built-in clock has no battery; module is detected and used automatically.
// - After rewrite and power cycle the error clears unless module is damaged.
// - No temperature compensation; only the fixed trim alters the rate.
package cce_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 32'h0000_000A;
	localparam int SEC_NS = 32'h3B9A_CA00;
	localparam int CYC_PER_SEC = SEC_NS / CLK_PERIOD_NS;
	localparam int XTAL_HZ = 32'h0000_8000;
	localparam int CAL_WINDOW_H = 32'h0000_0048;
	localparam int SEC_PER_H = 32'h0000_0E10;
	localparam int CAL_WINDOW_S = CAL_WINDOW_H * SEC_PER_H;
	localparam logic [4:0] ABSENT_LIMIT_S = 5'h0F;

	// Register byte offsets
	localparam logic [7:0] OFS_YEAR = 8'h00;
	localparam logic [7:0] OFS_MONTH = 8'h04;
	localparam logic [7:0] OFS_DAY = 8'h08;
	localparam logic [7:0] OFS_WDAY = 8'h0C;
	localparam logic [7:0] OFS_HOUR = 8'h10;
	localparam logic [7:0] OFS_MIN = 8'h14;
	localparam logic [7:0] OFS_SEC = 8'h18;
	localparam logic [7:0] OFS_HMS = 8'h1C;
	localparam logic [7:0] OFS_STAT = 8'h20;
	localparam logic [7:0] OFS_CAL = 8'h24;
	localparam logic [7:0] OFS_IST = 8'h28;
	localparam logic [7:0] OFS_ICLR = 8'h2C;
	localparam logic [7:0] OFS_IEN = 8'h30;

	// Status and interrupt bit positions
	localparam int ST_ERR_BIT = 0;
	localparam int ST_LOST_BIT = 1;
	localparam int ST_FAULT_BIT = 2;
	localparam int ST_PRESENT_BIT = 3;
	localparam int ST_BAT_BIT = 4;
	localparam int IRQ_SEC_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;

	// Reset values: Saturday 2000-01-01 00:00:00
	localparam logic [15:0] RST_YEAR = 16'h07D0;
	localparam logic [15:0] RST_MONTH = 16'h0001;
	localparam logic [15:0] RST_DAY = 16'h0001;
	localparam logic [15:0] RST_WDAY = 16'h0006;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_CAL = 16'h0000;

	// Calendar limits
	localparam logic [15:0] SEC_MAX = 16'h003B;
	localparam logic [15:0] HOUR_MAX = 16'h0017;
	localparam logic [15:0] WDAY_MAX = 16'h0007;
	localparam logic [15:0] MONTH_MAX = 16'h000C;
	localparam logic [15:0] FIRST = 16'h0001;
	localparam logic [15:0] FEB = 16'h0002;
	localparam logic [15:0] LEAP_4 = 16'h0004;
	localparam logic [15:0] LEAP_100 = 16'h0064;
	localparam logic [15:0] LEAP_400 = 16'h0190;
	localparam logic [15:0] DAYS_28 = 16'h001C;
	localparam logic [15:0] DAYS_29 = 16'h001D;
	localparam logic [15:0] DAYS_30 = 16'h001E;
	localparam logic [15:0] DAYS_31 = 16'h001F;
	localparam logic [31:0] HMS_HOUR_W = 32'h0000_2710;
	localparam logic [31:0] HMS_MIN_W = 32'h0000_0064;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} cce_wb_req_type;

	typedef struct packed {
		logic present;
		logic bat_ok;
		logic fault;
		logic xtal;
	} cce_mod_type;

	typedef struct packed {
		logic [15:0] year;
		logic [15:0] month;
		logic [15:0] day;
		logic [15:0] wday;
		logic [15:0] hour;
		logic [15:0] minute;
		logic [15:0] second;
	} cce_time_type;

	typedef struct packed {
		cce_time_type t;
		logic [15:0] cal;
		logic [1:0] ist;
		logic [1:0] ien;
		logic init;
		logic lost;
		logic fault;
		logic err;
		logic [4:0] absent;
		logic ack;
		logic [31:0] rdat;
	} cce_main_type;

	typedef struct packed {
		logic [31:0] pre;
		logic [31:0] xcnt;
		logic xq;
		logic [17:0] acc;
		logic extra;
		logic adv;
		logic raw;
	} cce_tick_type;
endpackage

// >>> core/cce_tick.sv
`timescale 1ns/10ps
`default_nettype none
module cce_tick #(
	parameter int CYC_PER_SEC = cce_pkg::CYC_PER_SEC,
	parameter int XTAL_PER_SEC = cce_pkg::XTAL_HZ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic present_i,
	input wire logic xtal_i,
	input wire logic [15:0] cal_i,
	output logic adv_o,
	output logic raw_o
);
	cce_pkg::cce_tick_type st;
	cce_pkg::cce_tick_type next_st;
	localparam logic [18:0] WIN = 19'(cce_pkg::CAL_WINDOW_S);

	// Second sources, trim accumulator and advance pulses
	always_comb begin
		logic xsec;
		logic src;
		logic [16:0] mag;
		logic [18:0] sum;
		xsec = 1'b0;
		src = 1'b0;
		mag = '0;
		sum = '0;
		next_st = st;
		next_st.adv = st.extra;
		next_st.extra = 1'b0;
		next_st.raw = 1'b0;
		next_st.xq = xtal_i;
		// Built-in one-second prescaler
		if (st.pre == 32'(CYC_PER_SEC - 1)) begin
			next_st.pre = '0;
			next_st.raw = 1'b1;
		end else begin
			next_st.pre = st.pre + 32'h0000_0001;
		end
		// Crystal edges counted into seconds on the module
		if (xtal_i && !st.xq) begin
			if (st.xcnt == 32'(XTAL_PER_SEC - 1)) begin
				next_st.xcnt = '0;
				xsec = 1'b1;
			end else begin
				next_st.xcnt = st.xcnt + 32'h0000_0001;
			end
		end
		src = present_i ? xsec : next_st.raw;
		mag = cal_i[15] ? 17'({1'b0, ~cal_i}) + 17'h0_0001 : {1'b0, cal_i};
		sum = {1'b0, st.acc} + {2'b00, mag};
		// Spread the signed trim evenly over the window; rate has no other input
		if (src) begin
			if (present_i && mag != 17'h0_0000 && sum >= WIN) begin
				next_st.acc = 18'(sum - WIN);
				if (!cal_i[15]) begin
					next_st.adv = 1'b1;
					next_st.extra = 1'b1;
				end
			end else begin
				if (present_i) begin
					next_st.acc = sum[17:0];
				end
				next_st.adv = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign adv_o = st.adv;
	assign raw_o = st.raw;
endmodule
`default_nettype wire

// >>> core/cce_clock.sv
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module cce_clock #(
	parameter int CYC_PER_SEC = cce_pkg::CYC_PER_SEC,
	parameter int XTAL_PER_SEC = cce_pkg::XTAL_HZ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire cce_pkg::cce_wb_req_type wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire cce_pkg::cce_mod_type mod_i,
	output logic err_led_o,
	output logic irq_o
);
	cce_pkg::cce_main_type st;
	cce_pkg::cce_main_type next_st;
	logic adv;
	logic raw_sec;
	logic req_go;
	logic wr;
	logic [7:0] addr;
	logic [31:0] hms;
	logic [1:0] ev;
	logic [1:0] clr;

	// Leap year test
	function automatic logic is_leap(input logic [15:0] y);
		is_leap = (y % cce_pkg::LEAP_4 == 16'h0000)
			&& ((y % cce_pkg::LEAP_100 != 16'h0000)
			|| (y % cce_pkg::LEAP_400 == 16'h0000));
	endfunction

	// Days in a month of a given year
	function automatic logic [15:0] month_days(input logic [15:0] y, input logic [15:0] m);
		unique case (m)
			cce_pkg::FEB: month_days = is_leap(y) ? cce_pkg::DAYS_29 : cce_pkg::DAYS_28;
			16'h0004, 16'h0006, 16'h0009, 16'h000B: month_days = cce_pkg::DAYS_30;
			default: month_days = cce_pkg::DAYS_31;
		endcase
	endfunction

	// One-second step with full carry chain
	function automatic cce_pkg::cce_time_type step(input cce_pkg::cce_time_type t);
		cce_pkg::cce_time_type r;
		r = t;
		if (t.second >= cce_pkg::SEC_MAX) begin
			r.second = cce_pkg::RST_ZERO;
			if (t.minute >= cce_pkg::SEC_MAX) begin
				r.minute = cce_pkg::RST_ZERO;
				if (t.hour >= cce_pkg::HOUR_MAX) begin
					r.hour = cce_pkg::RST_ZERO;
					// Monday is 1, Sunday is 7
					if (t.wday >= cce_pkg::WDAY_MAX) begin
						r.wday = cce_pkg::FIRST;
					end else begin
						r.wday = t.wday + cce_pkg::FIRST;
					end
					if (t.day >= month_days(t.year, t.month)) begin
						r.day = cce_pkg::FIRST;
						if (t.month >= cce_pkg::MONTH_MAX) begin
							r.month = cce_pkg::FIRST;
							r.year = t.year + cce_pkg::FIRST;
						end else begin
							r.month = t.month + cce_pkg::FIRST;
						end
					end else begin
						r.day = t.day + cce_pkg::FIRST;
					end
				end else begin
					r.hour = t.hour + cce_pkg::FIRST;
				end
			end else begin
				r.minute = t.minute + cce_pkg::FIRST;
			end
		end else begin
			r.second = t.second + cce_pkg::FIRST;
		end
		step = r;
	endfunction

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		merge16 = old;
		if (sel[0]) begin
			merge16[7:0] = d[7:0];
		end
		if (sel[1]) begin
			merge16[15:8] = d[15:8];
		end
	endfunction

	// Second source: module crystal when fitted, else internal prescaler
	cce_tick #(
		.CYC_PER_SEC(CYC_PER_SEC),
		.XTAL_PER_SEC(XTAL_PER_SEC)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.present_i(mod_i.present),
		.xtal_i(mod_i.xtal),
		.cal_i(st.cal),
		.adv_o(adv),
		.raw_o(raw_sec)
	);

	// Bus decode
	// Writes land on the acknowledge edge, so a request held until ack writes once
	assign req_go = wb_req_i.cyc && wb_req_i.stb;
	assign wr = req_go && st.ack && wb_req_i.we;
	assign addr = {wb_req_i.adr[7:2], 2'b00};

	// Packed time of day, no leading zero on the hour
	assign hms = 32'(st.t.hour) * cce_pkg::HMS_HOUR_W
		+ 32'(st.t.minute) * cce_pkg::HMS_MIN_W
		+ 32'(st.t.second);

	// Next-state logic
	always_comb begin
		logic [31:0] rv;
		rv = '0;
		next_st = st;
		next_st.init = 1'b0;
		next_st.ack = req_go && !st.ack;
		// Power-up check: no module or no battery means data lost
		if (st.init) begin
			next_st.lost = !mod_i.present || !mod_i.bat_ok;
		end
		// Battery missing from a fitted module for the limit time
		if (mod_i.present && !mod_i.bat_ok) begin
			if (raw_sec && st.absent != cce_pkg::ABSENT_LIMIT_S) begin
				next_st.absent = st.absent + 5'h01;
			end
		end else begin
			next_st.absent = '0;
		end
		if (st.absent == cce_pkg::ABSENT_LIMIT_S) begin
			next_st.lost = 1'b1;
		end
		// Damage or corruption is sticky until the next power-up
		if (mod_i.fault) begin
			next_st.fault = 1'b1;
		end
		next_st.err = next_st.lost || next_st.fault;
		// Timekeeping advance
		if (adv) begin
			next_st.t = step(st.t);
		end
		// Register writes take effect on the acknowledging edge
		// Placed after the advance so a same-cycle write wins for its field
		if (wr) begin
			unique case (addr)
				cce_pkg::OFS_YEAR: next_st.t.year = merge16(st.t.year, wb_req_i.dat,
					wb_req_i.sel);
				cce_pkg::OFS_MONTH: next_st.t.month = merge16(st.t.month, wb_req_i.dat,
					wb_req_i.sel);
				cce_pkg::OFS_DAY: next_st.t.day = merge16(st.t.day, wb_req_i.dat,
					wb_req_i.sel);
				cce_pkg::OFS_WDAY: next_st.t.wday = merge16(st.t.wday, wb_req_i.dat,
					wb_req_i.sel);
				cce_pkg::OFS_HOUR: next_st.t.hour = merge16(st.t.hour, wb_req_i.dat,
					wb_req_i.sel);
				cce_pkg::OFS_MIN: next_st.t.minute = merge16(st.t.minute, wb_req_i.dat,
					wb_req_i.sel);
				cce_pkg::OFS_SEC: next_st.t.second = merge16(st.t.second, wb_req_i.dat,
					wb_req_i.sel);
				cce_pkg::OFS_CAL: next_st.cal = merge16(st.cal, wb_req_i.dat,
					wb_req_i.sel);
				cce_pkg::OFS_IEN: begin
					if (wb_req_i.sel[0]) begin
						next_st.ien = wb_req_i.dat[1:0];
					end
				end
				default: begin
				end
			endcase
		end
		// Sticky events, set wins over a same-cycle clear
		ev = '0;
		ev[cce_pkg::IRQ_SEC_BIT] = adv;
		ev[cce_pkg::IRQ_ERR_BIT] = next_st.err && !st.err;
		clr = (wr && addr == cce_pkg::OFS_ICLR && wb_req_i.sel[0])
			? wb_req_i.dat[1:0] : 2'b00;
		next_st.ist = (st.ist & ~clr) | ev;
		// Read mux, captured with the acknowledge
		unique case (addr)
			cce_pkg::OFS_YEAR: rv = {16'h0000, st.t.year};
			cce_pkg::OFS_MONTH: rv = {16'h0000, st.t.month};
			cce_pkg::OFS_DAY: rv = {16'h0000, st.t.day};
			cce_pkg::OFS_WDAY: rv = {16'h0000, st.t.wday};
			cce_pkg::OFS_HOUR: rv = {16'h0000, st.t.hour};
			cce_pkg::OFS_MIN: rv = {16'h0000, st.t.minute};
			cce_pkg::OFS_SEC: rv = {16'h0000, st.t.second};
			cce_pkg::OFS_HMS: rv = hms;
			cce_pkg::OFS_STAT: begin
				rv[cce_pkg::ST_ERR_BIT] = st.err;
				rv[cce_pkg::ST_LOST_BIT] = st.lost;
				rv[cce_pkg::ST_FAULT_BIT] = st.fault;
				rv[cce_pkg::ST_PRESENT_BIT] = mod_i.present;
				rv[cce_pkg::ST_BAT_BIT] = mod_i.bat_ok;
			end
			cce_pkg::OFS_CAL: rv = {16'h0000, st.cal};
			cce_pkg::OFS_IST: rv = {30'h0000_0000, st.ist};
			cce_pkg::OFS_IEN: rv = {30'h0000_0000, st.ien};
			default: rv = '0;
		endcase
		if (req_go && !st.ack) begin
			next_st.rdat = wb_req_i.we ? 32'h0000_0000 : rv;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.t.year <= cce_pkg::RST_YEAR;
			st.t.month <= cce_pkg::RST_MONTH;
			st.t.day <= cce_pkg::RST_DAY;
			st.t.wday <= cce_pkg::RST_WDAY;
			st.cal <= cce_pkg::RST_CAL;
			st.init <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.rdat;
	assign err_led_o = st.err;
	assign irq_o = |(st.ist & st.ien);

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");

	a_ack_follows: assert property (req_go && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged in one cycle");

	a_write_sets_hour: assert property (wr && addr == cce_pkg::OFS_HOUR
		&& wb_req_i.sel == 4'hF |=> st.t.hour == $past(wb_req_i.dat[15:0]))
		else $error("hour write did not land");

	a_sec_carry: assert property (adv && !wr && st.t.second == cce_pkg::SEC_MAX
		&& st.t.minute < cce_pkg::SEC_MAX
		|=> st.t.second == 16'h0000 && st.t.minute == $past(st.t.minute) + 16'h0001)
		else $error("second did not carry into minute");

	a_wday_wrap: assert property (adv && !wr && st.t.second == cce_pkg::SEC_MAX
		&& st.t.minute == cce_pkg::SEC_MAX && st.t.hour == cce_pkg::HOUR_MAX
		&& st.t.wday == cce_pkg::WDAY_MAX |=> st.t.wday == 16'h0001)
		else $error("Sunday did not wrap to Monday");

	a_leap_day: assert property (adv && !wr && st.t.second == cce_pkg::SEC_MAX
		&& st.t.minute == cce_pkg::SEC_MAX && st.t.hour == cce_pkg::HOUR_MAX
		&& st.t.month == cce_pkg::FEB && st.t.day == cce_pkg::DAYS_28
		&& is_leap(st.t.year) |=> st.t.day == cce_pkg::DAYS_29)
		else $error("leap day skipped");

	a_year_carry: assert property (adv && !wr && st.t.second == cce_pkg::SEC_MAX
		&& st.t.minute == cce_pkg::SEC_MAX && st.t.hour == cce_pkg::HOUR_MAX
		&& st.t.month == cce_pkg::MONTH_MAX && st.t.day == cce_pkg::DAYS_31
		|=> st.t.year == $past(st.t.year) + 16'h0001 && st.t.month == 16'h0001)
		else $error("full year did not increment");

	a_powerup_lost: assert property (st.init && !mod_i.present
		|=> ##1 err_led_o)
		else $error("missing module did not raise error");

	a_fault_err: assert property (mod_i.fault |=> ##1 err_led_o[*3])
		else $error("fault did not hold error");

	a_absent_lost: assert property (st.absent == cce_pkg::ABSENT_LIMIT_S
		|=> st.lost ##1 err_led_o)
		else $error("battery absence did not mark data lost");

	a_hms_read: assert property (req_go && !wb_ack_o && !wb_req_i.we
		&& addr == cce_pkg::OFS_HMS |=> wb_ack_o && wb_dat_o == $past(hms))
		else $error("packed time read wrong");

	a_err_irq: assert property ($rose(st.err) && st.ien[cce_pkg::IRQ_ERR_BIT]
		|-> irq_o)
		else $error("error event missed interrupt");

	// Error flags are sticky until the next power-up
	a_err_sticky: assert property (err_led_o |=> err_led_o)
		else $error("error indicator dropped without reset");

	a_fault_sticky: assert property (st.fault |=> st.fault)
		else $error("fault flag dropped without reset");

	a_clean_powerup: assert property (st.init && mod_i.present && mod_i.bat_ok
		|=> !st.lost)
		else $error("healthy module still marked data lost");

	// Absence timer only moves on built-in seconds and restarts once the battery is back
	a_absent_hold: assert property (mod_i.present && !mod_i.bat_ok && !raw_sec
		|=> st.absent == $past(st.absent))
		else $error("absence timer moved without a second");

	a_absent_clear: assert property (!(mod_i.present && !mod_i.bat_ok)
		|=> st.absent == 5'h00)
		else $error("absence timer not cleared");

	// Calendar carry chain
	a_sec_step: assert property (adv && !wr && st.t.second < cce_pkg::SEC_MAX
		|=> st.t.second == $past(st.t.second) + 16'h0001)
		else $error("second did not step by one");

	a_min_carry: assert property (adv && !wr && st.t.second == cce_pkg::SEC_MAX
		&& st.t.minute == cce_pkg::SEC_MAX && st.t.hour < cce_pkg::HOUR_MAX
		|=> st.t.minute == 16'h0000 && st.t.hour == $past(st.t.hour) + 16'h0001)
		else $error("minute did not carry into hour");

	a_wday_step: assert property (adv && !wr && st.t.second == cce_pkg::SEC_MAX
		&& st.t.minute == cce_pkg::SEC_MAX && st.t.hour == cce_pkg::HOUR_MAX
		&& st.t.wday < cce_pkg::WDAY_MAX |=> st.t.wday == $past(st.t.wday) + 16'h0001)
		else $error("weekday did not step at midnight");

	a_feb_common: assert property (adv && !wr && st.t.second == cce_pkg::SEC_MAX
		&& st.t.minute == cce_pkg::SEC_MAX && st.t.hour == cce_pkg::HOUR_MAX
		&& st.t.month == cce_pkg::FEB && st.t.day == cce_pkg::DAYS_28
		&& !is_leap(st.t.year) |=> st.t.day == cce_pkg::FIRST && st.t.month == 16'h0003)
		else $error("common-year February did not end on the 28th");

	// Read data path
	a_write_data_zero: assert property (wr |-> wb_dat_o == 32'h0000_0000)
		else $error("write returned nonzero read data");

	a_rdat_hold: assert property (!(req_go && !wb_ack_o) |=> $stable(wb_dat_o))
		else $error("read data changed without a request");

	c_write_ack: cover property (wr);
	c_day_roll: cover property (adv && st.t.hour == cce_pkg::HOUR_MAX
		&& st.t.minute == cce_pkg::SEC_MAX && st.t.second == cce_pkg::SEC_MAX);
	c_error_seen: cover property ($rose(err_led_o));
	c_irq_raised: cover property ($rose(irq_o));
	c_double_step: cover property (adv ##1 adv);
endmodule
`default_nettype wire

// >>> dv/tb_cce_clock.sv
`timescale 1ns/10ps
`default_nettype none
module tb_cce_clock;
	localparam int CPS = 20;
	localparam int XPS = 4;
	localparam int LIMIT = 20000;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	cce_pkg::cce_wb_req_type req = '0;
	cce_pkg::cce_mod_type mod = 4'hC;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic err_led_o;
	logic irq_o;
	logic [31:0] rd;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;

	cce_clock #(.CYC_PER_SEC(CPS), .XTAL_PER_SEC(XPS)) i_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_req_i(req),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.mod_i(mod),
		.err_led_o(err_led_o),
		.irq_o(irq_o)
	);

	// Clock
	always #5 clk_i = ~clk_i;

	// Hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (fail_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One classic bus cycle, held until ack
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 50) chk("wb_ack", 32'h1, 32'h0);
		rd = wb_dat_o;
		req <= '0;
		@(posedge clk_i);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		chk(name, exp, rd);
	endtask

	task automatic pin_chk(input string name, input logic exp, input logic got);
		chk(name, {31'h0, exp}, {31'h0, got});
	endtask

	task automatic do_reset(input logic [3:0] m);
		mod <= m;
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	// Crystal edges for n module seconds, then settle
	task automatic xsec(input int n);
		repeat (n * XPS) begin
			mod.xtal <= 1'b1;
			repeat (2) @(posedge clk_i);
			mod.xtal <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		repeat (6) @(posedge clk_i);
	endtask

	function automatic cce_pkg::cce_time_type mk(input logic [15:0] y, input logic [7:0] mo,
		input logic [7:0] d, input logic [7:0] w, input logic [7:0] h, input logic [7:0] mi,
		input logic [7:0] s);
		mk = {y, 8'h00, mo, 8'h00, d, 8'h00, w, 8'h00, h, 8'h00, mi, 8'h00, s};
	endfunction

	task automatic set_t(input cce_pkg::cce_time_type t);
		for (int i = 0; i < 7; i++) begin
			wb(1'b1, cce_pkg::OFS_YEAR + 8'(4 * i), {16'h0000, t[111 - 16 * i -: 16]});
		end
	endtask

	task automatic chk_t(input cce_pkg::cce_time_type t);
		for (int i = 0; i < 7; i++) begin
			rd_chk($sformatf("field %0d", i), cce_pkg::OFS_YEAR + 8'(4 * i),
				{16'h0000, t[111 - 16 * i -: 16]});
		end
	endtask

	task automatic roll(input cce_pkg::cce_time_type a, input cce_pkg::cce_time_type b);
		set_t(a);
		xsec(1);
		chk_t(b);
	endtask

	// Trim of one full accumulator step each way
	task automatic t_cal();
		wb(1'b1, cce_pkg::OFS_CAL, 32'h0000_7FFF);
		wb(1'b1, cce_pkg::OFS_SEC, 32'h0);
		xsec(8);
		rd_chk("sec after plus trim", cce_pkg::OFS_SEC, 32'h9);
		wb(1'b1, cce_pkg::OFS_CAL, 32'h0000_8001);
		wb(1'b1, cce_pkg::OFS_SEC, 32'h0);
		xsec(8);
		rd_chk("sec after minus trim", cce_pkg::OFS_SEC, 32'h7);
		rd_chk("cal readback", cce_pkg::OFS_CAL, 32'h0000_8001);
		wb(1'b1, cce_pkg::OFS_CAL, 32'h0);
		wb(1'b1, cce_pkg::OFS_SEC, 32'h0);
		xsec(3);
		rd_chk("sec untrimmed", cce_pkg::OFS_SEC, 32'h3);
	endtask

	task automatic t_hms();
		set_t(mk(16'h07D8, 8'h0A, 8'h01, 8'h03, 8'h0C, 8'h1F, 8'h2D));
		rd_chk("hms noon", cce_pkg::OFS_HMS, 32'h0001_E109);
		set_t(mk(16'h07D8, 8'h0A, 8'h01, 8'h03, 8'h01, 8'h00, 8'h0F));
		rd_chk("hms one", cce_pkg::OFS_HMS, 32'h0000_271F);
	endtask

	task automatic t_irq();
		wb(1'b1, cce_pkg::OFS_ICLR, 32'h3);
		rd_chk("irq status cleared", cce_pkg::OFS_IST, 32'h0);
		wb(1'b1, cce_pkg::OFS_IEN, 32'h1);
		pin_chk("irq idle", 1'b0, irq_o);
		xsec(1);
		rd_chk("irq status tick", cce_pkg::OFS_IST, 32'h1);
		pin_chk("irq raised", 1'b1, irq_o);
		wb(1'b1, cce_pkg::OFS_IEN, 32'h0);
		pin_chk("irq masked", 1'b0, irq_o);
		rd_chk("irq enable", cce_pkg::OFS_IEN, 32'h0);
		wb(1'b1, cce_pkg::OFS_ICLR, 32'h1);
		rd_chk("irq status after clear", cce_pkg::OFS_IST, 32'h0);
		rd_chk("clear reads zero", cce_pkg::OFS_ICLR, 32'h0);
		rd_chk("unmapped", 8'h3C, 32'h0);
	endtask

	// Module chosen as time source when fitted
	task automatic t_source();
		wb(1'b0, cce_pkg::OFS_STAT, 32'h0);
		pin_chk("status present", 1'b1, rd[cce_pkg::ST_PRESENT_BIT]);
		wb(1'b1, cce_pkg::OFS_SEC, 32'h0);
		repeat (3 * CPS) @(posedge clk_i);
		rd_chk("sec idle crystal", cce_pkg::OFS_SEC, 32'h0);
		mod.present <= 1'b0;
		wb(1'b1, cce_pkg::OFS_SEC, 32'h0);
		repeat (CPS + 10) @(posedge clk_i);
		wb(1'b0, cce_pkg::OFS_SEC, 32'h0);
		pin_chk("sec built-in", 1'b1, rd == 32'h1 || rd == 32'h2);
		mod.present <= 1'b1;
	endtask

	task automatic t_fault();
		wb(1'b1, cce_pkg::OFS_IEN, 32'h2);
		pin_chk("irq before error", 1'b0, irq_o);
		mod.fault <= 1'b1;
		@(posedge clk_i);
		mod.fault <= 1'b0;
		repeat (3) @(posedge clk_i);
		pin_chk("led on fault", 1'b1, err_led_o);
		pin_chk("irq on error", 1'b1, irq_o);
		repeat (10) @(posedge clk_i);
		wb(1'b0, cce_pkg::OFS_STAT, 32'h0);
		pin_chk("status err", 1'b1, rd[cce_pkg::ST_ERR_BIT]);
		pin_chk("status fault", 1'b1, rd[cce_pkg::ST_FAULT_BIT]);
		pin_chk("led sticky", 1'b1, err_led_o);
		wb(1'b0, cce_pkg::OFS_IST, 32'h0);
		pin_chk("irq err bit", 1'b1, rd[cce_pkg::IRQ_ERR_BIT]);
		do_reset(4'hC);
		pin_chk("led after clean restart", 1'b0, err_led_o);
		do_reset(4'hE);
		pin_chk("led damaged module", 1'b1, err_led_o);
	endtask

	task automatic t_absent();
		do_reset(4'h8);
		pin_chk("led no battery", 1'b1, err_led_o);
		wb(1'b0, cce_pkg::OFS_STAT, 32'h0);
		pin_chk("status lost", 1'b1, rd[cce_pkg::ST_LOST_BIT]);
		pin_chk("status battery", 1'b0, rd[cce_pkg::ST_BAT_BIT]);
		do_reset(4'hC);
		pin_chk("led battery ok", 1'b0, err_led_o);
		mod.bat_ok <= 1'b0;
		repeat (12 * CPS) @(posedge clk_i);
		pin_chk("led short removal", 1'b0, err_led_o);
		repeat (6 * CPS) @(posedge clk_i);
		pin_chk("led long removal", 1'b1, err_led_o);
		do_reset(4'hC);
	endtask

	// Main sequence
	initial begin
		@(posedge clk_i);
		do_reset(4'hC);
		chk_t(mk(16'h07D0, 8'h01, 8'h01, 8'h06, 8'h00, 8'h00, 8'h00));
		pin_chk("led at start", 1'b0, err_led_o);
		t_cal();
		set_t(mk(16'h07D8, 8'h0A, 8'h01, 8'h03, 8'h0E, 8'h1E, 8'h01));
		chk_t(mk(16'h07D8, 8'h0A, 8'h01, 8'h03, 8'h0E, 8'h1E, 8'h01));
		t_hms();
		roll(mk(16'h07D8, 8'h0A, 8'h01, 8'h03, 8'h0E, 8'h1E, 8'h3B),
			mk(16'h07D8, 8'h0A, 8'h01, 8'h03, 8'h0E, 8'h1F, 8'h00));
		roll(mk(16'h07D8, 8'h0A, 8'h01, 8'h03, 8'h0E, 8'h3B, 8'h3B),
			mk(16'h07D8, 8'h0A, 8'h01, 8'h03, 8'h0F, 8'h00, 8'h00));
		roll(mk(16'h07E8, 8'h02, 8'h1C, 8'h03, 8'h17, 8'h3B, 8'h3B),
			mk(16'h07E8, 8'h02, 8'h1D, 8'h04, 8'h00, 8'h00, 8'h00));
		roll(mk(16'h07E7, 8'h02, 8'h1C, 8'h02, 8'h17, 8'h3B, 8'h3B),
			mk(16'h07E7, 8'h03, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00));
		roll(mk(16'h0834, 8'h02, 8'h1C, 8'h07, 8'h17, 8'h3B, 8'h3B),
			mk(16'h0834, 8'h03, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00));
		roll(mk(16'h07D0, 8'h02, 8'h1C, 8'h01, 8'h17, 8'h3B, 8'h3B),
			mk(16'h07D0, 8'h02, 8'h1D, 8'h02, 8'h00, 8'h00, 8'h00));
		roll(mk(16'h07E7, 8'h0C, 8'h1F, 8'h07, 8'h17, 8'h3B, 8'h3B),
			mk(16'h07E8, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00));
		t_irq();
		t_source();
		t_fault();
		t_absent();
		end_of_test();
	end
endmodule
`default_nettype wire
